// *** dv/lrp_mem_model.sv ***
// Purpose: array and SRAM stand-in behind the read port
// Assumes: same clock as the port
// Notes: returns address-derived words so every word is checkable
`timescale 1ns/1ns
`default_nettype none

module lrp_mem_model #(
	parameter int LAT = 3
) (
	// Clock
	input wire logic clk,
	// Array side
	input wire logic arr_rd_q,
	input wire logic arr_mask_q,
	input wire logic [15:0] arr_addr_q,
	output logic [71:0] arr_rdata,
	// SRAM side
	input wire logic sram_rd_q,
	input wire logic [18:0] sram_addr_q,
	output logic sram_valid,
	output logic [71:0] sram_rdata
);
	logic [71:0] word_q;
	int wait_q = 0;

	// Outside the strobe a flipped word, so a late sample shows up
	assign arr_rdata = arr_rd_q ? {55'h0, arr_mask_q, arr_addr_q} : ~{55'h0, arr_mask_q, arr_addr_q};
	// SRAM answers after its own latency, not the array timing
	assign sram_valid = (wait_q == 1);
	assign sram_rdata = sram_valid ? word_q : ~word_q;
	always @(posedge clk) begin
		if (sram_rd_q) begin
			wait_q <= LAT;
			word_q <= {53'h1, sram_addr_q};
		end else if (wait_q != 0) begin
			wait_q <= wait_q - 1;
		end
	end
endmodule // lrp_mem_model

`default_nettype wire

// *** dv/lrp_read_port_properties.sv ***
// Purpose: protocol checks on the read port pins
// Assumes: one clock, asynchronous active low reset
// Notes: bound to every lrp_read_port instance
`timescale 1ns/1ns
`default_nettype none

module lrp_read_chk #(
	parameter LEN_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pins watched
	input wire logic [71:0] dq_out_q,
	input wire logic dq_oe_q,
	input wire logic ack_out_q,
	input wire logic ack_oe_q,
	input wire logic end_of_transfer_q,
	input wire logic end_of_transfer_oe_q,
	input wire logic arr_rd_q,
	input wire logic [15:0] arr_addr_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ------------------------------------------------------------
	// Handshake shape
	// ------------------------------------------------------------
	ack_start_low_a: assert property ($rose(ack_oe_q) |-> !ack_out_q && dq_oe_q && dq_out_q == 72'h0)
		else $error("acknowledge did not start low with bus driven");
	ack_then_data_a: assert property ($rose(ack_oe_q) |=> ack_out_q)
		else $error("no data cycle after acknowledge start");
	ack_pulse_a: assert property (ack_out_q |=> !ack_out_q && ack_oe_q)
		else $error("acknowledge high longer than one cycle");
	single_tail_a: assert property ($rose(ack_oe_q) && !end_of_transfer_oe_q |-> ##1 ack_out_q
		##1 (!dq_oe_q && !ack_out_q && ack_oe_q) ##1 !ack_oe_q)
		else $error("single read tail wrong");
	dq_with_ack_a: assert property (dq_oe_q |-> ack_oe_q)
		else $error("bus driven without acknowledge enable");
	array_to_data_a: assert property (arr_rd_q |=> ack_out_q && dq_oe_q)
		else $error("array access not followed by data");
	// Burst framing
	eot_start_a: assert property ($rose(end_of_transfer_oe_q) |-> $rose(ack_oe_q)
		&& !end_of_transfer_q)
		else $error("end of transfer did not start low with acknowledge");
	eot_last_a: assert property (end_of_transfer_q |-> ack_out_q ##1 (!end_of_transfer_q
		&& !dq_oe_q && !ack_out_q && end_of_transfer_oe_q)
		##1 (!ack_oe_q && !end_of_transfer_oe_q))
		else $error("burst end framing wrong");
	burst_step_a: assert property ((arr_rd_q && end_of_transfer_oe_q) ##2 arr_rd_q
		|-> arr_addr_q == $past(arr_addr_q, 2) + 16'h1)
		else $error("burst address did not advance by one");
endmodule // lrp_read_chk

bind lrp_read_port lrp_read_chk #(.LEN_W(LEN_W)) chk (.clk(clk), .arst_n(arst_n),
	.dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .ack_out_q(ack_out_q), .ack_oe_q(ack_oe_q),
	.end_of_transfer_q(end_of_transfer_q), .end_of_transfer_oe_q(end_of_transfer_oe_q),
	.arr_rd_q(arr_rd_q), .arr_addr_q(arr_addr_q));

`default_nettype wire

// *** dv/lrp_read_port_tb.sv ***
// Purpose: self-checking bench for the read port
// Assumes: host on the same clock, single-rate commands
// Notes: each command is watched for a fixed 30 cycle window
`timescale 1ns/1ns
`default_nettype none
`include "lrp_regs.vh"

module lrp_read_port_tb;
	logic clk, arst_n, command_valid, reg_wr, reg_rd, dq_oe_q, ack_out_q, ack_oe_q;
	logic end_of_transfer_q, end_of_transfer_oe_q, arr_rd_q, arr_mask_q, sram_rd_q, sram_valid;
	logic [10:0] cmd;
	logic [71:0] dq_h, dq_out_q, arr_rdata, sram_rdata;
	logic [15:0] arr_addr_q;
	logic [18:0] sram_addr_q;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q;
	int mismatches = 0;
	int check_count = 0;
	// Shared DQ wire: host released shows an inverted pattern
	wire [71:0] dq_w = dq_oe_q ? dq_out_q : dq_h;

	lrp_read_port #(.LEN_W(8)) uut (.clk(clk), .arst_n(arst_n), .cmd(cmd),
		.command_valid(command_valid), .dq_in(dq_w), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q),
		.ack_out_q(ack_out_q), .ack_oe_q(ack_oe_q), .end_of_transfer_q(end_of_transfer_q),
		.end_of_transfer_oe_q(end_of_transfer_oe_q), .arr_rd_q(arr_rd_q), .arr_mask_q(arr_mask_q),
		.arr_addr_q(arr_addr_q), .arr_rdata(arr_rdata), .sram_rd_q(sram_rd_q),
		.sram_addr_q(sram_addr_q), .sram_valid(sram_valid), .sram_rdata(sram_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q));
	lrp_mem_model #(.LAT(3)) mem (.clk(clk), .arr_rd_q(arr_rd_q), .arr_mask_q(arr_mask_q),
		.arr_addr_q(arr_addr_q), .arr_rdata(arr_rdata), .sram_rd_q(sram_rd_q),
		.sram_addr_q(sram_addr_q), .sram_valid(sram_valid), .sram_rdata(sram_rdata));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata_q, exp);
	endtask

	function automatic logic [71:0] aw(logic ind, logic [2:0] idx, logic [4:0] id,
		logic [1:0] tgt, logic [15:0] a);
		return {42'h0, ind, idx, id, tgt, 3'h0, a};
	endfunction

	// One command, then n words expected from d0 upward; n of 0 means ignored
	task automatic run(input logic [10:0] c, input logic [71:0] w, input int n,
		input logic [71:0] d0);
		int cyc, k, eots, last;
		k = 0;
		eots = 0;
		last = 0;
		@(posedge clk);
		cmd <= c;
		command_valid <= 1'b1;
		dq_h <= w;
		@(posedge clk);
		command_valid <= 1'b0;
		dq_h <= ~w;
		for (cyc = 2; cyc <= 30; cyc++) begin
			#1;
			if (ack_oe_q) last = cyc;
			if (end_of_transfer_oe_q && !c[2]) eots += 100;
			if (end_of_transfer_q) eots += (ack_out_q && k == n - 1) ? 1 : 100;
			if (ack_out_q) begin
				chk(dq_out_q, d0 + k);
				k++;
			end
			@(posedge clk);
		end
		chk(k, n);
		chk(eots, (c[2] && n != 0) ? 1 : 0);
		if (w[20:19] != `LRP_TGT_SRAM) chk(last, n ? 4 + 2 * n : 0);
	endtask

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#200000;
		mismatches++;
		tally_and_finish;
	end

	initial begin
		arst_n = 1'b0; cmd = 11'h0; command_valid = 1'b0; dq_h = 72'h0;
		reg_addr = 8'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_reg(`LRP_OFS_RBR, 32'h0);
		rd_reg(8'h10, 32'h0);
		wr_reg(`LRP_OFS_CTRL, 32'h3);
		wr_reg(`LRP_OFS_SSR0 + 8'h8, 32'h1234);
		run(11'h0, aw(0, 0, 3, 0, 16'h0042), 1, {55'h0, 1'b0, 16'h0042});
		run(11'h0, aw(0, 0, 3, 1, 16'hfffe), 1, {55'h0, 1'b1, 16'hfffe});
		run(11'h0, aw(1, 2, 3, 0, 16'h0c01), 1, {55'h0, 1'b0, 16'h1235});
		run(11'h0, aw(0, 0, 4, 0, 16'h0001), 0, 72'h0);
		run(11'h1, aw(0, 0, 3, 0, 16'h0001), 0, 72'h0);
		run(11'h0, aw(0, 0, 5'h1f, 0, 16'h0001), 0, 72'h0);
		wr_reg(`LRP_OFS_CTRL, 32'h103);
		run(11'h0, aw(0, 0, 5'h1f, 0, 16'h0007), 1, {55'h0, 1'b0, 16'h0007});
		run(11'h140, aw(0, 0, 3, 2, 16'h0777), 1, {53'h1, 3'h5, 16'h0777});
		for (int i = 0; i < 2; i++) begin
			wr_reg(`LRP_OFS_RBR, i ? 32'h0300fe : 32'h0100a0);
			run(11'h4, aw(0, 0, 3, i[0], 16'h5555), i ? 3 : 1,
				{55'h0, i[0], i ? 16'h00fe : 16'h00a0});
		end
		rd_reg(`LRP_OFS_RBR, 32'h0300fe);
		run(11'h0, aw(0, 0, 3, 3, 16'h0001), 1, {40'h0, 32'h000300fe});
		run(11'h4, aw(0, 0, 3, 2, 16'h0000), 0, 72'h0);
		rd_reg(`LRP_OFS_STAT, 32'h00000101);
		tally_and_finish;
	end
endmodule // lrp_read_port_tb

`default_nettype wire

// *** logic/lrp_addr_gen.v ***
// Purpose: decode of the read address word into target and location
// Assumes: pure combinational, used inside lrp_read_port
// Notes: the selected search result value is supplied by the caller
`timescale 1ns/1ns
`default_nettype none
`include "lrp_regs.vh"

module lrp_addr_gen (
	// Address word and context
	input wire [29:0] dq_word,
	input wire [15:0] ssr_val,
	input wire burst,
	input wire [15:0] burst_addr,
	input wire [4:0] dev_id,
	input wire last_dev,
	// Decoded fields
	output wire [1:0] target,
	output wire [2:0] ssr_index,
	output wire [15:0] loc_addr,
	output wire selected
);
	wire [4:0] id_field;
	wire [15:0] ind_addr;

	// Target select and search result index
	assign target = dq_word[`LRP_DQ_TGT_HI:`LRP_DQ_TGT_LO];
	assign ssr_index = dq_word[`LRP_DQ_SEARCH_RESULT_REGISTER_INDEX_HI:`LRP_DQ_SEARCH_RESULT_REGISTER_INDEX_LO];
	assign id_field = dq_word[`LRP_DQ_ID_HI:`LRP_DQ_ID_LO];

	// Indirect form keeps the low two bits open for the host to OR in
	assign ind_addr = {ssr_val[15:2], ssr_val[1:0] | dq_word[1:0]};

	// Burst ignores the DQ location field entirely
	assign loc_addr = burst ? burst_addr :
		(dq_word[`LRP_DQ_IND_BIT] ? ind_addr : dq_word[15:0]);

	// All-ones reaches only the device flagged as last
	assign selected = (id_field == `LRP_ID_ALL) ? last_dev : (id_field == dev_id);
endmodule // lrp_addr_gen

`default_nettype wire

// *** logic/lrp_read_port.v ***
// Purpose: read command engine on the host port of a lookup device
// Assumes: host runs on clk; array and SRAM reached through side ports
// Notes: DQ, acknowledge and end of transfer come out as value plus enable
//
// Summary of operation
// - Command code 00 on the low command bits means read.
// - Command bit 2 low: single read of array, SRAM or register from DQ.
// - Command bit 2 high: burst of array locations, auto-incrementing address.
// - Single array or register read lasts exactly six cycles.
// - Respond only on ID match; all ones selects the last-device flagged part.
// - Cycle 4: device drives DQ and acknowledge low.
// - Cycle 5: device drives read data and acknowledge high.
// - Cycle 6: DQ floats, acknowledge low, then acknowledge floats.
// - SRAM reads have their own latency.
// - Burst lasts 4 + 2n cycles.
// - Burst cycle 4: drive DQ, acknowledge and end of transfer low.
// - Burst repeats the low/data pair for every access.
// - End of transfer high with the last data word.
// - Cycle 4 + 2n: DQ floats, both strobes low, acknowledge then floats.
// - Burst uses the internal read_burst_address, not DQ bits 15:0.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "lrp_regs.vh"

module lrp_read_port #(
	parameter LEN_W = 8
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Host command port
	input wire [10:0] cmd,
	input wire command_valid,
	input wire [71:0] dq_in,
	output reg [71:0] dq_out_q,
	output reg dq_oe_q,
	output reg ack_out_q,
	output reg ack_oe_q,
	output reg end_of_transfer_q,
	output reg end_of_transfer_oe_q,
	// Array port, read data valid in the cycle of the strobe
	output reg arr_rd_q,
	output reg arr_mask_q,
	output reg [15:0] arr_addr_q,
	input wire [71:0] arr_rdata,
	// External SRAM port
	output reg sram_rd_q,
	output reg [18:0] sram_addr_q,
	input wire sram_valid,
	input wire [71:0] sram_rdata,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q
);
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_TURN = 3'h1;
	localparam [2:0] ST_SWAIT = 3'h2;
	localparam [2:0] ST_LOW = 3'h3;
	localparam [2:0] ST_DATA = 3'h4;
	localparam [2:0] ST_END = 3'h5;
	localparam [23:0] RBR_RST = `LRP_RST_RBR;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg [2:0] st_q, st_d;
	reg [1:0] turn_q, turn_d;
	reg [LEN_W-1:0] left_q, left_d;
	reg [1:0] tgt_q, tgt_d;
	reg [15:0] addr_q, addr_d;
	reg burst_q, burst_d;
	reg [15:0] rba_q, rba_d;
	reg [71:0] sbuf_q, sbuf_d;
	reg [4:0] dev_id_q;
	reg last_device_flag_q;
	reg [15:0] rbr_addr_q;
	reg [LEN_W-1:0] rbr_len_q;
	reg [15:0] ssr_q [0:7];
	integer i;

	wire [1:0] dec_tgt;
	wire [2:0] dec_search_result_register_index;
	wire [15:0] dec_addr;
	wire dec_sel;
	wire is_burst;
	wire cmd_read;
	wire take;

	// ----------------------------------------------------------------
	// Shared register view, for the bus and for DQ register reads
	// ----------------------------------------------------------------
	function [31:0] reg_view;
		input [5:0] idx;
		reg [31:0] v;
		begin
			v = 32'h00000000;
			if (idx == `LRP_OFS_CTRL >> 2) begin
				v[4:0] = dev_id_q;
				v[`LRP_CTRL_LAST_DEVICE_FLAG_BIT] = last_device_flag_q;
			end else if (idx == `LRP_OFS_RBR >> 2) begin
				v[15:0] = rbr_addr_q;
				v[`LRP_RBR_LEN_LO +: LEN_W] = rbr_len_q;
			end else if (idx == `LRP_OFS_STAT >> 2) begin
				v[15:0] = rba_q;
				v[18:16] = st_q;
				v[19] = (st_q != ST_IDLE);
			end else if (idx >= (`LRP_OFS_SSR0 >> 2) && idx <= (`LRP_OFS_SSR7 >> 2)) begin
				v[15:0] = ssr_q[idx[2:0]];
			end
			reg_view = v;
		end
	endfunction

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign cmd_read = command_valid && (cmd[1:0] == `LRP_CMD_READ);
	assign is_burst = cmd[`LRP_CMD_BURST_BIT];
	// Host is on this clock, so the command is sampled in cycle 1 directly
	assign take = cmd_read && (st_q == ST_IDLE);

	lrp_addr_gen u_addr (
		.dq_word(dq_in[29:0]),
		.ssr_val(ssr_q[dec_search_result_register_index]),
		.burst(is_burst),
		.burst_addr(rbr_addr_q),
		.dev_id(dev_id_q),
		.last_dev(last_device_flag_q),
		.target(dec_tgt),
		.ssr_index(dec_search_result_register_index),
		.loc_addr(dec_addr),
		.selected(dec_sel)
	);

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always @* begin
		st_d = st_q;
		turn_d = turn_q;
		left_d = left_q;
		tgt_d = tgt_q;
		addr_d = addr_q;
		burst_d = burst_q;
		rba_d = rba_q;
		sbuf_d = sbuf_q;
		case (st_q)
			ST_IDLE: begin
				// Bursts of SRAM or registers are dropped, not half served
				if (take && dec_sel && !(is_burst && dec_tgt[1])) begin
					tgt_d = dec_tgt;
					addr_d = dec_addr;
					burst_d = is_burst;
					turn_d = `LRP_TURN_CYCLES - 2'h1;
					// Zero length is served as one access
					left_d = (is_burst && rbr_len_q != {LEN_W{1'b0}}) ?
						rbr_len_q : {{(LEN_W-1){1'b0}}, 1'b1};
					if (is_burst) begin
						rba_d = rbr_addr_q;
					end
					st_d = (dec_tgt == `LRP_TGT_SRAM) ? ST_SWAIT : ST_TURN;
				end
			end
			ST_TURN: begin
				// Cycles 2 and 3 leave the bus to turn around
				if (turn_q == 2'h0) begin
					st_d = ST_LOW;
				end else begin
					turn_d = turn_q - 2'h1;
				end
			end
			ST_SWAIT: begin
				// SRAM answers whenever it can; no fixed cycle count here
				if (sram_valid) begin
					sbuf_d = sram_rdata;
					st_d = ST_LOW;
				end
			end
			ST_LOW: begin
				left_d = left_q - {{(LEN_W-1){1'b0}}, 1'b1};
				if (burst_q) begin
					rba_d = rba_q + 16'h0001;
				end
				st_d = ST_DATA;
			end
			ST_DATA: begin
				st_d = (left_q == {LEN_W{1'b0}}) ? ST_END : ST_LOW;
			end
			ST_END: begin
				st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
			turn_q <= 2'h0;
			left_q <= {LEN_W{1'b0}};
			tgt_q <= `LRP_TGT_DATA;
			addr_q <= 16'h0000;
			burst_q <= 1'b0;
			rba_q <= 16'h0000;
			sbuf_q <= 72'h000000000000000000;
		end else begin
			st_q <= st_d;
			turn_q <= turn_d;
			left_q <= left_d;
			tgt_q <= tgt_d;
			addr_q <= addr_d;
			burst_q <= burst_d;
			rba_q <= rba_d;
			sbuf_q <= sbuf_d;
		end
	end

	// ----------------------------------------------------------------
	// Side port strobes, all registered
	// ----------------------------------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arr_rd_q <= 1'b0;
			arr_mask_q <= 1'b0;
			arr_addr_q <= 16'h0000;
			sram_rd_q <= 1'b0;
			sram_addr_q <= 19'h00000;
		end else begin
			// Array is strobed in each low cycle so data lands for the next
			arr_rd_q <= (st_d == ST_LOW) && !tgt_d[1];
			arr_mask_q <= (tgt_d == `LRP_TGT_MASK);
			arr_addr_q <= burst_d ? rba_d : addr_d;
			// One SRAM request, high address bits from the command bus
			sram_rd_q <= (st_q == ST_IDLE) && (st_d == ST_SWAIT);
			if ((st_q == ST_IDLE) && (st_d == ST_SWAIT)) begin
				sram_addr_q <= {cmd[`LRP_CMD_SRAM_HI:`LRP_CMD_SRAM_LO], dec_addr};
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers, taken from the state the next cycle will be in
	// ----------------------------------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_out_q <= 72'h000000000000000000;
			dq_oe_q <= 1'b0;
			ack_out_q <= 1'b0;
			ack_oe_q <= 1'b0;
			end_of_transfer_q <= 1'b0;
			end_of_transfer_oe_q <= 1'b0;
		end else begin
			dq_oe_q <= (st_d == ST_LOW) || (st_d == ST_DATA);
			ack_oe_q <= (st_d == ST_LOW) || (st_d == ST_DATA) || (st_d == ST_END);
			ack_out_q <= (st_d == ST_DATA);
			end_of_transfer_oe_q <= burst_d && ((st_d == ST_LOW) || (st_d == ST_DATA) ||
				(st_d == ST_END));
			end_of_transfer_q <= burst_d && (st_d == ST_DATA) &&
				(left_d == {LEN_W{1'b0}});
			// Low cycles drive zeros so the bus is never left floating mid-pair
			if (st_d == ST_DATA) begin
				if (tgt_q == `LRP_TGT_SRAM) begin
					dq_out_q <= sbuf_q;
				end else if (tgt_q == `LRP_TGT_REG) begin
					dq_out_q <= {40'h0000000000, reg_view(addr_q[5:0])};
				end else begin
					dq_out_q <= arr_rdata;
				end
			end else begin
				dq_out_q <= 72'h000000000000000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dev_id_q <= `LRP_RST_DEV_ID;
			last_device_flag_q <= 1'b0;
			rbr_addr_q <= RBR_RST[15:0];
			rbr_len_q <= {LEN_W{1'b0}};
			for (i = 0; i < 8; i = i + 1) begin
				ssr_q[i] <= 16'h0000;
			end
		end else if (reg_wr) begin
			if (reg_addr[7:2] == `LRP_OFS_CTRL >> 2) begin
				dev_id_q <= reg_wdata[4:0];
				last_device_flag_q <= reg_wdata[`LRP_CTRL_LAST_DEVICE_FLAG_BIT];
			end else if (reg_addr[7:2] == `LRP_OFS_RBR >> 2) begin
				rbr_addr_q <= reg_wdata[15:0];
				rbr_len_q <= reg_wdata[`LRP_RBR_LEN_LO +: LEN_W];
			end else if (reg_addr[7:2] >= (`LRP_OFS_SSR0 >> 2) &&
				reg_addr[7:2] <= (`LRP_OFS_SSR7 >> 2)) begin
				ssr_q[reg_addr[4:2]] <= reg_wdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register reads, one cycle later; unmapped words read zero
	// ----------------------------------------------------------------
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata_q <= reg_view(reg_addr[7:2]);
		end else begin
			reg_rdata_q <= 32'h00000000;
		end
	end
endmodule // lrp_read_port

`default_nettype wire

// *** pkg/lrp_regs.vh ***
// Purpose: constants for the lookup array read port
// Assumes: one 50 MHz clock, byte addressed register port
// Notes: every offset and command field lives here; the STAT, CTRL ID and DQ location fields and the SSR count are in the RTL
`ifndef LRP_REGS_VH
`define LRP_REGS_VH

// ----------------------------------------------------------------
// Command bus fields
// ----------------------------------------------------------------
`define LRP_CMD_READ 2'h0
`define LRP_CMD_BURST_BIT 2
`define LRP_CMD_SRAM_HI 8
`define LRP_CMD_SRAM_LO 6

// ----------------------------------------------------------------
// Read address word on DQ
// ----------------------------------------------------------------
`define LRP_DQ_IND_BIT 29
`define LRP_DQ_SEARCH_RESULT_REGISTER_INDEX_HI 28
`define LRP_DQ_SEARCH_RESULT_REGISTER_INDEX_LO 26
`define LRP_DQ_ID_HI 25
`define LRP_DQ_ID_LO 21
`define LRP_DQ_TGT_HI 20
`define LRP_DQ_TGT_LO 19
`define LRP_DQ_REG_HI 6
`define LRP_ID_ALL 5'h1f
`define LRP_TGT_DATA 2'h0
`define LRP_TGT_MASK 2'h1
`define LRP_TGT_SRAM 2'h2
`define LRP_TGT_REG 2'h3

// ----------------------------------------------------------------
// Register map, byte offsets
// ----------------------------------------------------------------
`define LRP_OFS_CTRL 8'h00
`define LRP_OFS_RBR 8'h04
`define LRP_OFS_STAT 8'h08
`define LRP_OFS_SSR0 8'h20
`define LRP_OFS_SSR7 8'h3c
`define LRP_CTRL_LAST_DEVICE_FLAG_BIT 8
`define LRP_RBR_LEN_LO 16
`define LRP_RST_DEV_ID 5'h00
`define LRP_RST_RBR 24'h000000

// ----------------------------------------------------------------
// Timing, in clock cycles
// ----------------------------------------------------------------
`define LRP_TURN_CYCLES 2'h2
`define LRP_SINGLE_CYCLES 6

`endif
